/* hdl/swm_cfg_regs.v */
// Interrupt message, vendor capability, test, timer override and forwarding mode registers
`timescale 1ns/1ps
`default_nettype none
`include "swm_defs.vh"

module swm_cfg_regs (
	input wire mclk,
	input wire reset,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire [7:0] cfg_addr,
	input wire [3:0] cfg_be,
	input wire [31:0] cfg_wdata,
	output reg [31:0] cfg_rdata_r,
	output reg cfg_rd_valid_r,
	input wire smb_ld_valid,
	input wire [7:0] smb_ld_addr,
	input wire [31:0] smb_ld_data,
	input wire eep_ld_valid,
	input wire [7:0] eep_ld_addr,
	input wire [31:0] eep_ld_data,
	output wire eep_ld_ready,
	input wire msi_enable,
	input wire irq_level,
	output reg msi_wr_req_r,
	input wire msi_wr_ack,
	output reg [63:0] msi_wr_addr_r,
	output reg [15:0] msi_wr_data_r,
	output reg legacy_int_n_r,
	output wire msi_64bit_capable,
	input wire [11:0] builtin_replay,
	input wire [13:0] builtin_ack_lat,
	output reg [11:0] replay_timeout_r,
	output reg [13:0] ack_latency_r,
	output wire vga_decode_en,
	output wire pm_cap_disable,
	output wire msi_cap_disable,
	output wire store_forward,
	output wire [1:0] cut_threshold,
	input wire slow_to_fast,
	input wire [10:0] pkt_len,
	output wire [10:0] fwd_start
);
	reg [29:0] msg_addr_r;
	reg [31:0] msg_uaddr_r;
	reg [15:0] msg_data_r;
	reg [31:0] test0_r;
	reg [31:0] test1_r;
	reg [31:0] timer_r;
	reg [31:0] opmode_r;
	reg irq_level_d_r;
	wire [31:0] wmask;
	wire [31:0] msg_addr_rst;
	reg [31:0] rd_word;
	reg [31:0] timer_nxt;
	reg [31:0] opmode_nxt;
	wire ld_timer;
	wire ld_opmode;
	wire [31:0] ld_data;
	wire wr_addr;
	wire wr_uaddr;
	wire wr_data;
	wire wr_test0;
	wire wr_test1;
	wire wr_timer;
	wire wr_opmode;
	wire irq_rise;
	wire [31:0] timer_rst;
	wire [31:0] opmode_rst;
	genvar i;

	swm_preload u_preload (
		.smb_ld_valid(smb_ld_valid),
		.smb_ld_addr(smb_ld_addr),
		.smb_ld_data(smb_ld_data),
		.eep_ld_valid(eep_ld_valid),
		.eep_ld_addr(eep_ld_addr),
		.eep_ld_data(eep_ld_data),
		.eep_ld_ready(eep_ld_ready),
		.ld_timer(ld_timer),
		.ld_opmode(ld_opmode),
		.ld_data(ld_data)
	);

	// Byte enables expand to a bit mask
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_be
			assign wmask[i*8+7:i*8] = {8{cfg_be[i]}};
		end
	endgenerate

	assign wr_addr = cfg_wr & (cfg_addr == `SWM_OFF_MSG_ADDR);
	assign wr_uaddr = cfg_wr & (cfg_addr == `SWM_OFF_MSG_UADDR);
	assign wr_data = cfg_wr & (cfg_addr == `SWM_OFF_MSG_DATA);
	assign wr_test0 = cfg_wr & (cfg_addr == `SWM_OFF_TEST0);
	assign wr_test1 = cfg_wr & (cfg_addr == `SWM_OFF_TEST1);
	assign wr_timer = cfg_wr & (cfg_addr == `SWM_OFF_TIMER);
	assign wr_opmode = cfg_wr & (cfg_addr == `SWM_OFF_OPMODE);

	assign timer_rst = {`SWM_RST_VGA, 1'b0, `SWM_RST_ACKLAT, 3'h0, 1'b0, `SWM_RST_REPLAY};
	assign opmode_rst = {29'h0, `SWM_RST_THR, `SWM_RST_STORE_FWD};
	assign msg_addr_rst = `SWM_RST_MSG_ADDR;

	// Timer and mode words: preload first, then a configuration write on top
	always @* begin
		timer_nxt = timer_r;
		if (ld_timer) begin
			timer_nxt = (timer_nxt & ~`SWM_TMR_LD_MASK) | (ld_data & `SWM_TMR_LD_MASK);
		end
		if (wr_timer) begin
			timer_nxt = (timer_nxt & ~(wmask & `SWM_TMR_WR_MASK)) |
				(cfg_wdata & wmask & `SWM_TMR_WR_MASK);
		end
		timer_nxt[`SWM_TMR_VGA] = `SWM_RST_VGA;
		timer_nxt[15] = 1'b0;
		opmode_nxt = opmode_r;
		if (ld_opmode) begin
			opmode_nxt = (opmode_nxt & ~`SWM_OPM_MASK) | (ld_data & `SWM_OPM_MASK);
		end
		if (wr_opmode) begin
			opmode_nxt = (opmode_nxt & ~(wmask & `SWM_OPM_MASK)) | (cfg_wdata & wmask & `SWM_OPM_MASK);
		end
	end

	always @(posedge mclk) begin
		if (reset) begin
			msg_addr_r <= msg_addr_rst[31:`SWM_MSI_ADDR_LSB];
			msg_uaddr_r <= `SWM_RST_MSG_UADDR;
			msg_data_r <= `SWM_RST_MSG_DATA;
			test0_r <= `SWM_RST_TEST0;
			test1_r <= `SWM_RST_TEST1;
			timer_r <= timer_rst;
			opmode_r <= opmode_rst;
		end else begin
			if (wr_addr) begin
				msg_addr_r <= (msg_addr_r & ~wmask[31:2]) | (cfg_wdata[31:2] & wmask[31:2]);
			end
			if (wr_uaddr) begin
				msg_uaddr_r <= (msg_uaddr_r & ~wmask) | (cfg_wdata & wmask);
			end
			if (wr_data) begin
				msg_data_r <= (msg_data_r & ~wmask[15:0]) | (cfg_wdata[15:0] & wmask[15:0]);
			end
			if (wr_test0) begin
				test0_r <= (test0_r & ~wmask) | (cfg_wdata & wmask);
			end
			if (wr_test1) begin
				test1_r <= (test1_r & ~wmask) | (cfg_wdata & wmask);
			end
			timer_r <= timer_nxt;
			opmode_r <= opmode_nxt;
		end
	end

	// Read multiplexer; unmapped offsets and reserved bits read zero
	always @* begin
		case (cfg_addr)
			`SWM_OFF_MSG_ADDR: rd_word = {msg_addr_r, 2'h0};
			`SWM_OFF_MSG_UADDR: rd_word = msg_uaddr_r;
			`SWM_OFF_MSG_DATA: rd_word = {16'h0000, msg_data_r};
			`SWM_OFF_VND_CAP: rd_word = {`SWM_VND_LENGTH, `SWM_VND_NEXT_PTR, `SWM_VND_CAP_ID};
			`SWM_OFF_TEST0: rd_word = test0_r;
			`SWM_OFF_TEST1: rd_word = test1_r;
			`SWM_OFF_TIMER: rd_word = timer_r;
			`SWM_OFF_OPMODE: rd_word = opmode_r;
			default: rd_word = 32'h00000000;
		endcase
	end

	always @(posedge mclk) begin
		if (reset) begin
			cfg_rdata_r <= 32'h00000000;
			cfg_rd_valid_r <= 1'b0;
		end else begin
			cfg_rd_valid_r <= cfg_rd;
			if (cfg_rd) begin
				cfg_rdata_r <= rd_word;
			end
		end
	end

	// Timer selection between user and built-in values
	always @(posedge mclk) begin
		if (reset) begin
			replay_timeout_r <= 12'h000;
			ack_latency_r <= 14'h0000;
		end else begin
			replay_timeout_r <= timer_r[`SWM_TMR_REPLAY_EN] ?
				timer_r[`SWM_TMR_REPLAY_MSB:0] : builtin_replay;
			ack_latency_r <= timer_r[`SWM_TMR_ACK_EN] ?
				timer_r[`SWM_TMR_ACK_MSB:`SWM_TMR_ACK_LSB] : builtin_ack_lat;
		end
	end

	assign vga_decode_en = timer_r[`SWM_TMR_VGA];
	assign pm_cap_disable = timer_r[`SWM_TMR_PM_DIS];
	assign msi_cap_disable = timer_r[`SWM_TMR_MSI_DIS];
	assign store_forward = opmode_r[`SWM_OPM_STORE_FWD];
	assign cut_threshold = opmode_r[`SWM_OPM_THR_MSB:`SWM_OPM_THR_LSB];
	assign msi_64bit_capable = `SWM_MSI_64CAP;

	// Interrupt delivery: message on a rising request while messages are enabled, else the legacy pin
	assign irq_rise = irq_level & ~irq_level_d_r;

	always @(posedge mclk) begin
		if (reset) begin
			irq_level_d_r <= 1'b0;
			msi_wr_req_r <= 1'b0;
			msi_wr_addr_r <= 64'h0000000000000000;
			msi_wr_data_r <= 16'h0000;
			legacy_int_n_r <= 1'b1;
		end else begin
			irq_level_d_r <= irq_level;
			legacy_int_n_r <= ~(irq_level & ~msi_enable);
			if (msi_wr_req_r & msi_wr_ack) begin
				msi_wr_req_r <= 1'b0;
			end else if (irq_rise & msi_enable & ~msi_wr_req_r) begin
				msi_wr_req_r <= 1'b1;
				msi_wr_addr_r <= {(`SWM_MSI_64CAP ? msg_uaddr_r : 32'h00000000), msg_addr_r, 2'h0};
				msi_wr_data_r <= msg_data_r;
			end
		end
	end

	swm_fwd_ctrl u_fwd (
		.mclk(mclk),
		.reset(reset),
		.store_fwd(store_forward),
		.threshold(cut_threshold),
		.slow_to_fast(slow_to_fast),
		.pkt_len(pkt_len),
		.fwd_start_r(fwd_start)
	);
endmodule // swm_cfg_regs

`default_nettype wire

/* include/swm_defs.vh */
// Offsets, field positions, reset values and preload masks for the switch config slice
`ifndef SWM_DEFS_VH
`define SWM_DEFS_VH

// Dword offsets, byte addressed
`define SWM_OFF_MSG_ADDR 8'h50
`define SWM_OFF_MSG_UADDR 8'h54
`define SWM_OFF_MSG_DATA 8'h58
`define SWM_OFF_VND_CAP 8'h64
`define SWM_OFF_TEST0 8'h68
`define SWM_OFF_TEST1 8'h6C
`define SWM_OFF_TIMER 8'h70
`define SWM_OFF_OPMODE 8'h74

// Reset values
`define SWM_RST_MSG_ADDR 32'h00000000
`define SWM_RST_MSG_UADDR 32'h00000000
`define SWM_RST_MSG_DATA 16'h0000
`define SWM_RST_TEST0 32'h04001060
`define SWM_RST_TEST1 32'h00000800
`define SWM_RST_REPLAY 12'h000
`define SWM_RST_ACKLAT 14'h0000

// Vendor capability header fields
`define SWM_VND_CAP_ID 8'h09
`define SWM_VND_NEXT_PTR 8'hB0
`define SWM_VND_LENGTH 16'h0034

// Message capability bits that this slice relies on
`define SWM_MSI_64CAP 1'h1
`define SWM_MSI_ADDR_LSB 2

// Timer word field positions
`define SWM_TMR_REPLAY_MSB 11
`define SWM_TMR_REPLAY_EN 12
`define SWM_TMR_PM_DIS 13
`define SWM_TMR_MSI_DIS 14
`define SWM_TMR_ACK_LSB 16
`define SWM_TMR_ACK_MSB 29
`define SWM_TMR_ACK_EN 30
`define SWM_TMR_VGA 31
`define SWM_RST_VGA 1'h1

// Timer word: software writable bits and preloadable bits
`define SWM_TMR_WR_MASK 32'h7FFF1FFF
`define SWM_TMR_LD_MASK 32'h7FFF7FFF

// Operation mode field positions
`define SWM_OPM_STORE_FWD 0
`define SWM_OPM_THR_LSB 1
`define SWM_OPM_THR_MSB 2
`define SWM_OPM_MASK 32'h00000007
`define SWM_RST_STORE_FWD 1'h0
`define SWM_RST_THR 2'h0

// Cut-through threshold codes
`define SWM_THR_MID 2'h0
`define SWM_THR_EARLY1 2'h1
`define SWM_THR_EARLY2 2'h2
`define SWM_THR_EARLY3 2'h3

`endif

/* hdl/swm_preload.v */
// Default preload arbiter between the serial management bus and the serial memory loader
`timescale 1ns/1ps
`default_nettype none
`include "swm_defs.vh"

module swm_preload (
	input wire smb_ld_valid,
	input wire [7:0] smb_ld_addr,
	input wire [31:0] smb_ld_data,
	input wire eep_ld_valid,
	input wire [7:0] eep_ld_addr,
	input wire [31:0] eep_ld_data,
	output wire eep_ld_ready,
	output wire ld_timer,
	output wire ld_opmode,
	output wire [31:0] ld_data
);
	wire use_smb;
	wire ld_valid;
	wire [7:0] ld_addr;

	// Management bus has priority; the serial memory loader stalls behind it
	assign use_smb = smb_ld_valid;
	assign eep_ld_ready = ~smb_ld_valid;
	assign ld_valid = smb_ld_valid | eep_ld_valid;
	assign ld_addr = use_smb ? smb_ld_addr : eep_ld_addr;
	assign ld_data = use_smb ? smb_ld_data : eep_ld_data;
	assign ld_timer = ld_valid & (ld_addr == `SWM_OFF_TIMER);
	assign ld_opmode = ld_valid & (ld_addr == `SWM_OFF_OPMODE);
endmodule // swm_preload

`default_nettype wire

/* hdl/swm_fwd_ctrl.v */
// Forwarding start point from store-and-forward and cut-through threshold settings
`timescale 1ns/1ps
`default_nettype none
`include "swm_defs.vh"

module swm_fwd_ctrl (
	input wire mclk,
	input wire reset,
	input wire store_fwd,
	input wire [1:0] threshold,
	input wire slow_to_fast,
	input wire [10:0] pkt_len,
	output reg [10:0] fwd_start_r
);
	reg [10:0] fwd_start_nxt;
	reg [10:0] mid;
	reg [10:0] ahead;

	always @* begin
		mid = {1'b0, pkt_len[10:1]};
		case (threshold)
			`SWM_THR_MID: ahead = 11'h000;
			`SWM_THR_EARLY1: ahead = 11'h001;
			`SWM_THR_EARLY2: ahead = 11'h002;
			`SWM_THR_EARLY3: ahead = 11'h003;
			default: ahead = 11'h000;
		endcase
		if (store_fwd) begin
			fwd_start_nxt = pkt_len;
		end else if (slow_to_fast) begin
			fwd_start_nxt = (mid > ahead) ? (mid - ahead) : 11'h000;
		end else begin
			fwd_start_nxt = 11'h000;
		end
	end

	always @(posedge mclk) begin
		if (reset) begin
			fwd_start_r <= 11'h000;
		end else begin
			fwd_start_r <= fwd_start_nxt;
		end
	end
endmodule // swm_fwd_ctrl

`default_nettype wire

/* tb/swm_rc_model.sv */
// Root complex model issuing configuration reads and writes
`timescale 1ns/1ps
`default_nettype none
module swm_rc_model (
	input wire logic mclk,
	output logic cfg_wr,
	output logic cfg_rd,
	output logic [7:0] cfg_addr,
	output logic [3:0] cfg_be,
	output logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata_r
);
	initial begin
		cfg_wr = 1'h0;
		cfg_rd = 1'h0;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h00000000;
	end
	// Released lines carry the inverse of their last value
	task wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		@(posedge mclk);
		cfg_wr <= 1'h1;
		cfg_addr <= a;
		cfg_be <= b;
		cfg_wdata <= d;
		@(posedge mclk);
		cfg_wr <= 1'h0;
		cfg_addr <= ~a;
		cfg_be <= ~b;
		cfg_wdata <= ~d;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		cfg_rd <= 1'h1;
		cfg_addr <= a;
		@(posedge mclk);
		cfg_rd <= 1'h0;
		cfg_addr <= ~a;
		@(negedge mclk);
		d = cfg_rdata_r;
	endtask
endmodule // swm_rc_model
`default_nettype wire

/* tb/swm_cfg_regs_chk.sv */
// Port checker for the switch configuration register slice
`timescale 1ns/1ps
`default_nettype none
module swm_cfg_regs_chk (
	input wire logic mclk,
	input wire logic reset,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_rdata_r,
	input wire logic cfg_rd_valid_r,
	input wire logic msi_enable,
	input wire logic irq_level,
	input wire logic msi_wr_req_r,
	input wire logic msi_wr_ack,
	input wire logic [63:0] msi_wr_addr_r,
	input wire logic legacy_int_n_r,
	input wire logic msi_64bit_capable,
	input wire logic vga_decode_en,
	input wire logic store_forward,
	input wire logic [1:0] cut_threshold,
	input wire logic slow_to_fast,
	input wire logic [10:0] pkt_len,
	input wire logic [10:0] fwd_start
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	a_read_answer: assert property (cfg_rd |=> cfg_rd_valid_r)
		else $error("read not answered");
	a_valid_alone: assert property (!cfg_rd |=> !cfg_rd_valid_r)
		else $error("stray read valid");
	a_cap_header: assert property (cfg_rd && cfg_addr == 8'h64
		|=> cfg_rdata_r == 32'h0034B009) else $error("bad capability header");
	a_fixed_bits: assert property (msi_64bit_capable && vga_decode_en)
		else $error("fixed bit low");
	a_msi_launch: assert property ($rose(irq_level) && msi_enable && !msi_wr_req_r
		|=> msi_wr_req_r && msi_wr_addr_r[1:0] == 2'h0) else $error("message not raised");
	a_msi_hold: assert property (msi_wr_req_r && !msi_wr_ack |=> msi_wr_req_r)
		else $error("request dropped early");
	a_msi_drop: assert property (msi_wr_req_r && msi_wr_ack |=> !msi_wr_req_r)
		else $error("request kept after ack");
	a_legacy_quiet: assert property (msi_enable |=> legacy_int_n_r)
		else $error("pin used with messages on");
	a_legacy_drive: assert property (irq_level && !msi_enable |=> !legacy_int_n_r)
		else $error("pin not driven");
	a_store_fwd: assert property (store_forward |=> fwd_start == $past(pkt_len))
		else $error("store-forward start wrong");
	a_thr_early: assert property (slow_to_fast && !store_forward && pkt_len >= 11'h008
		|=> fwd_start == ($past(pkt_len) >> 1) - $past(cut_threshold))
		else $error("threshold start wrong");
endmodule // swm_cfg_regs_chk
bind swm_cfg_regs swm_cfg_regs_chk u_swm_cfg_regs_chk (.mclk, .reset, .cfg_rd, .cfg_addr,
	.cfg_rdata_r, .cfg_rd_valid_r, .msi_enable, .irq_level, .msi_wr_req_r, .msi_wr_ack,
	.msi_wr_addr_r, .legacy_int_n_r, .msi_64bit_capable, .vga_decode_en, .store_forward,
	.cut_threshold, .slow_to_fast, .pkt_len, .fwd_start);
`default_nettype wire

/* tb/swm_cfg_regs_bench.sv */
// Self-checking bench for the switch configuration register slice
`timescale 1ns/1ps
`default_nettype none
module swm_cfg_regs_bench;
	logic mclk = 1'h0;
	logic reset = 1'h1;
	logic cfg_wr, cfg_rd, cfg_rd_valid_r, eep_ld_ready, msi_wr_req_r, legacy_int_n_r;
	logic msi_64bit_capable, vga_decode_en, pm_cap_disable, msi_cap_disable, store_forward;
	logic [7:0] cfg_addr;
	logic [3:0] cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata_r;
	logic [63:0] msi_wr_addr_r;
	logic [15:0] msi_wr_data_r;
	logic [11:0] replay_timeout_r;
	logic [13:0] ack_latency_r;
	logic [1:0] cut_threshold;
	logic [10:0] fwd_start;
	logic smb_ld_valid = 1'h0, eep_ld_valid = 1'h0, msi_enable = 1'h0, irq_level = 1'h0;
	logic msi_wr_ack = 1'h0, slow_to_fast = 1'h0;
	logic [7:0] smb_ld_addr = 8'h00, eep_ld_addr = 8'h00;
	logic [31:0] smb_ld_data = 32'h00000000, eep_ld_data = 32'h00000000;
	logic [11:0] builtin_replay = 12'h5A5;
	logic [13:0] builtin_ack_lat = 14'h1234;
	logic [10:0] pkt_len = 11'h000;
	int mismatches = 0;
	int checks_done = 0;
	logic [7:0] offs [8] = '{8'h50, 8'h54, 8'h58, 8'h64, 8'h68, 8'h6C, 8'h70, 8'h74};
	logic [31:0] rstv [8] = '{32'h0, 32'h0, 32'h0, 32'h0034B009, 32'h04001060, 32'h00000800,
		32'h80000000, 32'h0};
	logic [31:0] onev [8] = '{32'hFFFFFFFC, 32'hFFFFFFFF, 32'h0000FFFF, 32'h0034B009,
		32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFF1FFF, 32'h00000007};
	swm_cfg_regs u_swm_cfg_regs (.mclk, .reset, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
		.cfg_wdata, .cfg_rdata_r, .cfg_rd_valid_r, .smb_ld_valid, .smb_ld_addr, .smb_ld_data,
		.eep_ld_valid, .eep_ld_addr, .eep_ld_data, .eep_ld_ready, .msi_enable, .irq_level,
		.msi_wr_req_r, .msi_wr_ack, .msi_wr_addr_r, .msi_wr_data_r, .legacy_int_n_r,
		.msi_64bit_capable, .builtin_replay, .builtin_ack_lat, .replay_timeout_r,
		.ack_latency_r, .vga_decode_en, .pm_cap_disable, .msi_cap_disable, .store_forward,
		.cut_threshold, .slow_to_fast, .pkt_len, .fwd_start);
	swm_rc_model u_swm_rc_model (.mclk, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
		.cfg_rdata_r);
	always #20 mclk = ~mclk;
	task chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		u_swm_rc_model.rd(a, d);
		chk(d, e);
		chk(cfg_rd_valid_r, 1'h1);
	endtask
	task tick;
		@(posedge mclk);
		@(negedge mclk);
	endtask
	task t_reset;
		for (int i = 0; i < 8; i++)
			rdc(offs[i], rstv[i]);
		rdc(8'h60, 32'h0);
		chk({legacy_int_n_r, store_forward, cut_threshold}, 4'h8);
		chk({msi_64bit_capable, vga_decode_en}, 2'h3);
		chk({replay_timeout_r, ack_latency_r}, {12'h5A5, 14'h1234});
	endtask
	task t_write;
		for (int i = 0; i < 8; i++) begin
			u_swm_rc_model.wr(offs[i], 4'hF, 32'hFFFFFFFF);
			rdc(offs[i], onev[i]);
		end
		chk({replay_timeout_r, ack_latency_r}, {12'hFFF, 14'h3FFF});
		chk({pm_cap_disable, msi_cap_disable, store_forward}, 3'h1);
		u_swm_rc_model.wr(8'h68, 4'h1, 32'h00000000);
		rdc(8'h68, 32'hFFFFFF00);
		u_swm_rc_model.wr(8'h70, 4'hF, 32'h00000000);
		tick;
		chk({replay_timeout_r, ack_latency_r}, {12'h5A5, 14'h1234});
	endtask
	task t_msi;
		u_swm_rc_model.wr(8'h50, 4'hF, 32'h12345677);
		u_swm_rc_model.wr(8'h54, 4'hF, 32'hA5A50001);
		u_swm_rc_model.wr(8'h58, 4'hF, 32'hDEADBEEF);
		rdc(8'h50, 32'h12345674);
		@(posedge mclk);
		msi_enable <= 1'h1;
		irq_level <= 1'h1;
		tick;
		chk({msi_wr_req_r, legacy_int_n_r}, 2'h3);
		chk(msi_wr_addr_r, 64'hA5A5000112345674);
		chk(msi_wr_data_r, 16'hBEEF);
		tick;
		chk(msi_wr_req_r, 1'h1);
		@(posedge mclk);
		msi_wr_ack <= 1'h1;
		@(posedge mclk);
		msi_wr_ack <= 1'h0;
		irq_level <= 1'h0;
		msi_enable <= 1'h0;
		@(negedge mclk);
		chk(msi_wr_req_r, 1'h0);
		@(posedge mclk);
		irq_level <= 1'h1;
		tick;
		tick;
		chk({msi_wr_req_r, legacy_int_n_r}, 2'h0);
		@(posedge mclk);
		irq_level <= 1'h0;
	endtask
	task t_fwd;
		@(posedge mclk);
		slow_to_fast <= 1'h1;
		pkt_len <= 11'h064;
		for (int t = 0; t < 4; t++) begin
			u_swm_rc_model.wr(8'h74, 4'hF, 32'(t * 2));
			tick;
			chk({cut_threshold, fwd_start}, {t[1:0], 11'h032 - 11'(t)});
		end
		u_swm_rc_model.wr(8'h74, 4'hF, 32'h00000007);
		tick;
		chk(fwd_start, 11'h064);
		@(posedge mclk);
		pkt_len <= 11'h005;
		u_swm_rc_model.wr(8'h74, 4'hF, 32'h00000006);
		tick;
		chk(fwd_start, 11'h000);
		@(posedge mclk);
		slow_to_fast <= 1'h0;
		pkt_len <= 11'h064;
		tick;
		chk(fwd_start, 11'h000);
	endtask
	task t_preload;
		@(posedge mclk);
		smb_ld_valid <= 1'h1;
		smb_ld_addr <= 8'h70;
		smb_ld_data <= 32'hFFFFFFFF;
		eep_ld_valid <= 1'h1;
		eep_ld_addr <= 8'h74;
		eep_ld_data <= 32'h00000003;
		@(negedge mclk);
		chk(eep_ld_ready, 1'h0);
		@(posedge mclk);
		smb_ld_valid <= 1'h0;
		smb_ld_data <= 32'h00000000;
		@(negedge mclk);
		chk(eep_ld_ready, 1'h1);
		@(posedge mclk);
		eep_ld_valid <= 1'h0;
		eep_ld_data <= 32'hFFFFFFFC;
		rdc(8'h70, 32'hFFFF7FFF);
		rdc(8'h74, 32'h00000003);
		chk({pm_cap_disable, msi_cap_disable, store_forward, cut_threshold}, 5'h1D);
		@(posedge mclk);
		reset <= 1'h1;
		@(posedge mclk);
		reset <= 1'h0;
		rdc(8'h70, 32'h80000000);
		rdc(8'h74, 32'h00000000);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		reset <= 1'h0;
		t_reset;
		t_write;
		t_msi;
		t_fwd;
		t_preload;
		test_done;
	end
	initial begin
		#200000;
		mismatches++;
		test_done;
	end
endmodule // swm_cfg_regs_bench
`default_nettype wire
